// ===== hw/ccs_top.sv
// The register offsets and register access over APB were chosen for this implementation.
`include "ccs_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ccs_top
(
   input  wire logic        I_CORE_CLK,
   input  wire logic        I_RST,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_OSC_SLEEP_STOP,
   input  wire logic        I_PLL_LOCK,
   input  wire logic        I_DFLL_ACK_TGL,
   input  wire logic [3:0]  I_DFLL_RDATA,
   output logic             O_IRQ,
   output logic             O_XIN_CTRL,
   output logic             O_CRYSTAL_OUT_PIN_CTRL,
   output logic             O_OSC_RUN,
   output logic             O_OSC_MODE,
   output logic             O_OSC_CLK_GATE,
   output logic             O_PLL_EN,
   output logic [1:0]       O_PLL_REF_SEL,
   output logic [5:0]       O_PLL_MUL,
   output logic [3:0]       O_PLL_DIV,
   output logic             O_PLL_DIV2,
   output logic             O_PLL_WIDE_BW,
   output logic             O_PLL_CLK_GATE,
   output logic [3:0]       O_DFLL_CONF,
   output logic             O_DFLL_REQ_TGL
);

   function automatic logic [15:0] su_cycles(input logic [3:0] sel);
      su_cycles = 16'h0001 << sel;
   endfunction

   logic [31:0]                   osc_q;
   logic [31:0]                   pll_q;
   logic [3:0]                    dfll_q;
   logic [`CCS_ST_W-1:0]          imr_q;
   logic [`CCS_ST_W-1:0]          isr_q;
   logic [`CCS_ST_W-1:0]          stat_prev_q;
   logic [`CCS_ST_W-1:0]          stat;
   logic                          unlock_q;
   logic [7:0]                    unlock_addr_q;
   ccs_pkg::ccs_osc_state_type    osc_st_q;
   logic [15:0]                   osc_cnt_q;
   logic                          lock_meta_q;
   logic                          lock_q;
   logic                          lock_prev_q;
   logic                          lost_q;
   logic                          dfll_rdy;
   logic [3:0]                    dfll_rd;
   logic                          wr;
   logic                          wr_pll;
   logic                          wr_dfll;
   logic                          sync_go;
   logic                          osc_want;
   logic [31:0]                   rd_d;
   logic                          err_d;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   // data is prepared in the setup cycle so that PRDATA leaves a flop
   assign wr      = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
   assign wr_pll  = wr && I_PADDR == `CCS_OFF_PLLCTRL
                    && unlock_q && unlock_addr_q == `CCS_OFF_PLLCTRL;
   assign wr_dfll = wr && I_PADDR == `CCS_OFF_DFLLCONF
                    && unlock_q && unlock_addr_q == `CCS_OFF_DFLLCONF
                    && dfll_rdy;
   assign sync_go = wr_dfll
                    || (wr && I_PADDR == `CCS_OFF_DFLLSYNC && I_PWDATA[`CCS_SYNC_BIT]);

   always_comb
   begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      case (I_PADDR)
         `CCS_OFF_IER, `CCS_OFF_IDR, `CCS_OFF_ICR, `CCS_OFF_UNLOCK, `CCS_OFF_DFLLSYNC:
            rd_d = 32'h0000_0000;
         `CCS_OFF_IMR:      rd_d[`CCS_ST_W-1:0] = imr_q;
         `CCS_OFF_ISR:      rd_d[`CCS_ST_W-1:0] = isr_q;
         `CCS_OFF_POWER_CLOCK_STATUS_REG:   rd_d[`CCS_ST_W-1:0] = stat;
         `CCS_OFF_OSCCTRL:  rd_d = osc_q;
         `CCS_OFF_PLLCTRL:  rd_d = pll_q;
         `CCS_OFF_DFLLCONF: rd_d[3:0] = dfll_q;
         `CCS_OFF_DFLLRD:   rd_d[3:0] = dfll_rd;
         default:           err_d = 1'b1;
      endcase
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_PREADY  <= 1'b0;
         O_PRDATA  <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PREADY  <= I_PSEL & ~I_PENABLE;
         O_PRDATA  <= (I_PSEL & ~I_PENABLE & ~I_PWRITE) ? rd_d : 32'h0000_0000;
         O_PSLVERR <= I_PSEL & ~I_PENABLE & err_d;
      end
   end

   // ------------------------------------------------------------
   // unlock
   // ------------------------------------------------------------
   // any other write closes it again, so a stray write cannot linger
   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         unlock_q      <= 1'b0;
         unlock_addr_q <= 8'h00;
      end
      else if (wr)
      begin
         if (I_PADDR == `CCS_OFF_UNLOCK && I_PWDATA[`CCS_KEY_HI:`CCS_KEY_LO] == `CCS_UNLOCK_KEY)
         begin
            unlock_q      <= 1'b1;
            unlock_addr_q <= I_PWDATA[7:0];
         end
         else
         begin
            unlock_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // main oscillator
   // ------------------------------------------------------------
   assign osc_want = osc_q[`CCS_OSC_EN] & ~I_OSC_SLEEP_STOP;

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         osc_q <= `CCS_OSC_RST;
      end
      else if (wr && I_PADDR == `CCS_OFF_OSCCTRL)
      begin
         osc_q <= I_PWDATA & `CCS_OSC_WMASK;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         osc_st_q  <= ccs_pkg::OSC_OFF;
         osc_cnt_q <= 16'h0000;
      end
      else
      begin
         case (osc_st_q)
            ccs_pkg::OSC_OFF:
            begin
               if (osc_want)
               begin
                  osc_cnt_q <= su_cycles(osc_q[`CCS_OSC_SU_HI:`CCS_OSC_SU_LO]);
                  osc_st_q  <= ccs_pkg::OSC_START;
               end
            end
            ccs_pkg::OSC_START:
            begin
               if (!osc_want)
               begin
                  osc_st_q <= ccs_pkg::OSC_OFF;
               end
               else if (osc_cnt_q == 16'h0001)
               begin
                  osc_cnt_q <= 16'h0000;
                  osc_st_q  <= ccs_pkg::OSC_READY;
               end
               else
               begin
                  osc_cnt_q <= osc_cnt_q - 16'h0001;
               end
            end
            ccs_pkg::OSC_READY:
            begin
               if (!osc_want)
               begin
                  osc_st_q <= ccs_pkg::OSC_OFF;
               end
            end
            default:
            begin
               osc_st_q <= ccs_pkg::OSC_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_XIN_CTRL     <= 1'b0;
         O_CRYSTAL_OUT_PIN_CTRL    <= 1'b0;
         O_OSC_RUN      <= 1'b0;
         O_OSC_MODE     <= 1'b0;
         O_OSC_CLK_GATE <= 1'b0;
      end
      else
      begin
         O_XIN_CTRL     <= osc_q[`CCS_OSC_EN];
         O_CRYSTAL_OUT_PIN_CTRL    <= osc_q[`CCS_OSC_EN] & osc_q[`CCS_OSC_MODE];
         O_OSC_RUN      <= osc_want;
         O_OSC_MODE     <= osc_q[`CCS_OSC_MODE];
         O_OSC_CLK_GATE <= (osc_st_q == ccs_pkg::OSC_READY) & osc_want;
      end
   end

   // ------------------------------------------------------------
   // phase locked loop
   // ------------------------------------------------------------
   // while enabled only the enable bit may change, so disabling stays possible
   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         pll_q <= `CCS_PLL_RST;
      end
      else if (wr_pll)
      begin
         if (pll_q[`CCS_PLL_EN])
         begin
            pll_q[`CCS_PLL_EN] <= pll_q[`CCS_PLL_EN] & I_PWDATA[`CCS_PLL_EN];
         end
         else
         begin
            pll_q <= I_PWDATA & `CCS_PLL_WMASK;
         end
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         lock_meta_q <= 1'b0;
         lock_q      <= 1'b0;
         lock_prev_q <= 1'b0;
      end
      else
      begin
         lock_meta_q <= I_PLL_LOCK;
         lock_q      <= lock_meta_q & pll_q[`CCS_PLL_EN];
         lock_prev_q <= lock_q;
      end
   end

   // cleared by a fresh enable; a loss in the same cycle still wins
   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         lost_q <= 1'b0;
      end
      else if (lock_prev_q & ~lock_q & pll_q[`CCS_PLL_EN])
      begin
         lost_q <= 1'b1;
      end
      else if (wr_pll && !pll_q[`CCS_PLL_EN] && I_PWDATA[`CCS_PLL_EN])
      begin
         lost_q <= 1'b0;
      end
   end

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         O_PLL_EN       <= 1'b0;
         O_PLL_REF_SEL  <= 2'h0;
         O_PLL_MUL      <= 6'h00;
         O_PLL_DIV      <= 4'h0;
         O_PLL_DIV2     <= 1'b0;
         O_PLL_WIDE_BW  <= 1'b0;
         O_PLL_CLK_GATE <= 1'b0;
      end
      else
      begin
         O_PLL_EN       <= pll_q[`CCS_PLL_EN];
         O_PLL_REF_SEL  <= pll_q[`CCS_PLL_OSC_HI:`CCS_PLL_OSC_LO];
         O_PLL_MUL      <= pll_q[`CCS_PLL_MUL_HI:`CCS_PLL_MUL_LO];
         O_PLL_DIV      <= pll_q[`CCS_PLL_DIV_HI:`CCS_PLL_DIV_LO];
         O_PLL_DIV2     <= pll_q[`CCS_PLL_OPT_DIV2];
         O_PLL_WIDE_BW  <= pll_q[`CCS_PLL_OPT_WBW];
         O_PLL_CLK_GATE <= lock_q & pll_q[`CCS_PLL_EN];
      end
   end

   // ------------------------------------------------------------
   // frequency locked loop
   // ------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         dfll_q <= `CCS_DFLL_RST;
      end
      else if (wr_dfll)
      begin
         dfll_q <= I_PWDATA[3:0] & `CCS_DFLL_WMASK;
      end
   end

   assign O_DFLL_CONF = dfll_q;

   ccs_loop_sync
   #(
      .W (`CCS_DFLL_W)
   )
   u_sync
   (
      .i_clk     (I_CORE_CLK),
      .i_rst     (I_RST),
      .i_start   (sync_go),
      .i_ack_tgl (I_DFLL_ACK_TGL),
      .i_rdata   (I_DFLL_RDATA),
      .o_req_tgl (O_DFLL_REQ_TGL),
      .o_ready   (dfll_rdy),
      .o_rdata   (dfll_rd)
   );

   // ------------------------------------------------------------
   // status and interrupts
   // ------------------------------------------------------------
   assign stat = {lost_q, lock_q, dfll_rdy, osc_st_q == ccs_pkg::OSC_READY};

   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         imr_q <= '0;
      end
      else if (wr && I_PADDR == `CCS_OFF_IER)
      begin
         imr_q <= imr_q | I_PWDATA[`CCS_ST_W-1:0];
      end
      else if (wr && I_PADDR == `CCS_OFF_IDR)
      begin
         imr_q <= imr_q & ~I_PWDATA[`CCS_ST_W-1:0];
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge I_CORE_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         stat_prev_q <= `CCS_ST_RST;
         isr_q       <= '0;
         O_IRQ       <= 1'b0;
      end
      else
      begin
         stat_prev_q <= stat;
         isr_q       <= (isr_q & ~((wr && I_PADDR == `CCS_OFF_ICR) ? I_PWDATA[`CCS_ST_W-1:0] : '0))
                        | (stat & ~stat_prev_q);
         O_IRQ       <= |(isr_q & imr_q);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_osc_pins;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      wr && I_PADDR == `CCS_OFF_OSCCTRL && I_PWDATA[`CCS_OSC_EN] |-> ##2 O_XIN_CTRL;
   endproperty
   a_osc_pins : assert property (p_osc_pins) else $error("crystal pins not taken");

   property p_crystal_out_pin;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      O_CRYSTAL_OUT_PIN_CTRL |-> O_XIN_CTRL;
   endproperty
   a_crystal_out_pin : assert property (p_crystal_out_pin) else $error("output pin taken without input pin");

   property p_su_load;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      osc_st_q == ccs_pkg::OSC_OFF && osc_want
      |=> osc_cnt_q == su_cycles(osc_q[`CCS_OSC_SU_HI:`CCS_OSC_SU_LO]);
   endproperty
   a_su_load : assert property (p_su_load) else $error("start-up count not loaded");

   property p_gate;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      osc_st_q != ccs_pkg::OSC_READY |=> !O_OSC_CLK_GATE;
   endproperty
   a_gate : assert property (p_gate) else $error("clock passed during start-up");

   property p_osc_irq;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      $rose(stat[`CCS_ST_OSCRDY]) && imr_q[`CCS_ST_OSCRDY] && !(wr && I_PADDR == `CCS_OFF_IDR) |-> ##2 O_IRQ;
   endproperty
   a_osc_irq : assert property (p_osc_irq) else $error("ready interrupt missing");

   property p_ier;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      wr && I_PADDR == `CCS_OFF_IER |=> (imr_q & $past(I_PWDATA[`CCS_ST_W-1:0])) == $past(I_PWDATA[`CCS_ST_W-1:0]);
   endproperty
   a_ier : assert property (p_ier) else $error("mask bit not set");

   property p_pll_gate;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      !lock_q |=> !O_PLL_CLK_GATE;
   endproperty
   a_pll_gate : assert property (p_pll_gate) else $error("loop clock passed while unlocked");

   property p_pll_locked;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      wr && I_PADDR == `CCS_OFF_PLLCTRL && !unlock_q |=> $stable(pll_q);
   endproperty
   a_pll_locked : assert property (p_pll_locked) else $error("protected write accepted");

   property p_pll_frozen;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      pll_q[`CCS_PLL_EN] |=> pll_q[31:1] == $past(pll_q[31:1]);
   endproperty
   a_pll_frozen : assert property (p_pll_frozen) else $error("config changed while enabled");

   property p_dfll_rdy;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      !dfll_rdy |=> $stable(dfll_q);
   endproperty
   a_dfll_rdy : assert property (p_dfll_rdy) else $error("write taken while not ready");

   property p_one_shot;
      @(posedge I_CORE_CLK) disable iff (I_RST)
      wr && I_PADDR != `CCS_OFF_UNLOCK |=> !unlock_q;
   endproperty
   a_one_shot : assert property (p_one_shot) else $error("unlock survived a write");

endmodule // ccs_top

`default_nettype wire

// ===== common/ccs_defines.svh
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CCS_OFF_IER      8'h00
`define CCS_OFF_IDR      8'h04
`define CCS_OFF_IMR      8'h08
`define CCS_OFF_ISR      8'h0c
`define CCS_OFF_ICR      8'h10
`define CCS_OFF_POWER_CLOCK_STATUS_REG   8'h14
`define CCS_OFF_UNLOCK   8'h18
`define CCS_OFF_OSCCTRL  8'h1c
`define CCS_OFF_PLLCTRL  8'h20
`define CCS_OFF_DFLLCONF 8'h24
`define CCS_OFF_DFLLSYNC 8'h28
`define CCS_OFF_DFLLRD   8'h2c

// ------------------------------------------------------------
// status / interrupt bit positions
// ------------------------------------------------------------
`define CCS_ST_OSCRDY    0
`define CCS_ST_DFLLRDY   1
`define CCS_ST_PLLLOCK   2
`define CCS_ST_PLLLOST   3
`define CCS_ST_W         4

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CCS_OSC_MODE     0
`define CCS_OSC_SU_LO    8
`define CCS_OSC_SU_HI    11
`define CCS_OSC_EN       16
`define CCS_OSC_WMASK    32'h0001_0f01
`define CCS_PLL_EN       0
`define CCS_PLL_OSC_LO   1
`define CCS_PLL_OSC_HI   2
`define CCS_PLL_OPT_LO   3
`define CCS_PLL_OPT_DIV2 3
`define CCS_PLL_OPT_WBW  4
`define CCS_PLL_OPT_HI   5
`define CCS_PLL_DIV_LO   8
`define CCS_PLL_DIV_HI   11
`define CCS_PLL_MUL_LO   16
`define CCS_PLL_MUL_HI   21
`define CCS_PLL_WMASK    32'h003f_0f3f
`define CCS_DFLL_W       4
`define CCS_DFLL_EN      0
`define CCS_DFLL_WMASK   4'hf
`define CCS_SYNC_BIT     0
`define CCS_KEY_LO       24
`define CCS_KEY_HI       31
`define CCS_UNLOCK_KEY   8'haa

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CCS_OSC_RST      32'h0000_0000
`define CCS_PLL_RST      32'h0000_0000
`define CCS_DFLL_RST     4'h0
// freq loop comes out of reset ready, so its edge detector must too
`define CCS_ST_RST       4'h2

`endif

// ===== common/ccs_pkg.sv
`default_nettype none

package ccs_pkg;

   typedef enum logic [2:0]
   {
      OSC_OFF   = 3'b001,
      OSC_START = 3'b010,
      OSC_READY = 3'b100
   } ccs_osc_state_type;

   typedef enum logic [1:0]
   {
      HS_IDLE = 2'b01,
      HS_BUSY = 2'b10
   } ccs_hs_state_type;

endpackage : ccs_pkg

`default_nettype wire

// ===== hw/ccs_loop_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ccs_loop_sync
#(
   parameter int W = 4
)
(
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_start,
   input  wire logic         i_ack_tgl,
   input  wire logic [W-1:0] i_rdata,
   output logic              o_req_tgl,
   output logic              o_ready,
   output logic [W-1:0]      o_rdata
);

   if (W < 1)
   begin : g_bad_w
      $error("ccs_loop_sync: W must be at least 1");
   end

   ccs_pkg::ccs_hs_state_type state_q;
   logic                      ack_meta_q;
   logic                      ack_q;

   // ------------------------------------------------------------
   // ack toggle synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ack_meta_q <= 1'b0;
         ack_q      <= 1'b0;
      end
      else
      begin
         ack_meta_q <= i_ack_tgl;
         ack_q      <= ack_meta_q;
      end
   end

   // ------------------------------------------------------------
   // toggle handshake
   // ------------------------------------------------------------
   // read data is only stable in the far domain once ack has come back
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q   <= ccs_pkg::HS_IDLE;
         o_req_tgl <= 1'b0;
         o_ready   <= 1'b1;
         o_rdata   <= '0;
      end
      else
      begin
         case (state_q)
            ccs_pkg::HS_IDLE:
            begin
               if (i_start)
               begin
                  o_req_tgl <= ~o_req_tgl;
                  o_ready   <= 1'b0;
                  state_q   <= ccs_pkg::HS_BUSY;
               end
            end
            ccs_pkg::HS_BUSY:
            begin
               if (ack_q == o_req_tgl)
               begin
                  o_rdata <= i_rdata;
                  o_ready <= 1'b1;
                  state_q <= ccs_pkg::HS_IDLE;
               end
            end
            default:
            begin
               state_q <= ccs_pkg::HS_IDLE;
               o_ready <= 1'b1;
            end
         endcase
      end
   end

   property p_ready_low_busy;
      @(posedge i_clk) disable iff (i_rst)
      (state_q == ccs_pkg::HS_BUSY) |-> !o_ready;
   endproperty
   a_ready_low_busy : assert property (p_ready_low_busy) else $error("ready high during transfer");

endmodule // ccs_loop_sync

`default_nettype wire

// ===== tb/tb_ccs_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ccs_top;

   // ------------------------------------------------------------
   // stimulus and observed signals
   // ------------------------------------------------------------
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic        slp = 1'b0;
   logic        lock = 1'b0;
   logic        ack = 1'b0;
   logic [3:0]  frd = 4'h0;
   logic [31:0] rd;
   logic        err;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, crystal_in_pin, crystal_out_pin, run, mode, ogate;
   logic        pll_en, div2, wbw, pgate, req;
   logic [1:0]  ref_sel;
   logic [5:0]  mul;
   logic [3:0]  div, dconf;
   int          checks = 0;
   int          bad_count = 0;

   always #20 clk = ~clk;

   ccs_top i_ccs_top
   (
      .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
      .I_PADDR(addr), .I_PWDATA(wd), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_OSC_SLEEP_STOP(slp), .I_PLL_LOCK(lock), .I_DFLL_ACK_TGL(ack), .I_DFLL_RDATA(frd),
      .O_IRQ(irq), .O_XIN_CTRL(crystal_in_pin), .O_CRYSTAL_OUT_PIN_CTRL(crystal_out_pin), .O_OSC_RUN(run), .O_OSC_MODE(mode),
      .O_OSC_CLK_GATE(ogate), .O_PLL_EN(pll_en), .O_PLL_REF_SEL(ref_sel), .O_PLL_MUL(mul),
      .O_PLL_DIV(div), .O_PLL_DIV2(div2), .O_PLL_WIDE_BW(wbw), .O_PLL_CLK_GATE(pgate),
      .O_DFLL_CONF(dconf), .O_DFLL_REQ_TGL(req)
   );

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic unl(input logic [7:0] a);
      wr(8'h18, {8'haa, 16'h0000, a});
   endtask

   // far side answers the toggle with stable readback, then ready is polled
   task automatic dans(input logic [3:0] v);
      cyc(3);
      frd <= v;
      ack <= req;
      do
      begin
         apb(1'b0, 8'h14, 32'h0);
      end
      while (rd[1] !== 1'b1);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk(crystal_in_pin, 0);
      chk(run, 0);
      chk(pll_en, 0);
      chk(pgate, 0);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h0000_0002);
   endtask

   task automatic t_osc;
      wr(8'h00, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 1);
      wr(8'h00, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 1);
      wr(8'h1c, 32'h0001_0201);
      cyc(2);
      chk(crystal_in_pin, 1);
      chk(crystal_out_pin, 1);
      chk(mode, 1);
      chk(ogate, 0);
      cyc(20);
      chk(ogate, 1);
      chk(irq, 1);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[0], 1);
      wr(8'h10, 32'h1);
      cyc(2);
      chk(irq, 0);
      slp <= 1'b1;
      cyc(3);
      chk(run, 0);
      chk(ogate, 0);
      slp <= 1'b0;
      cyc(2);
      chk(ogate, 0);
      cyc(20);
      chk(ogate, 1);
      wr(8'h1c, 32'h0001_0200);
      cyc(2);
      chk(crystal_out_pin, 0);
      chk(crystal_in_pin, 1);
      chk(mode, 0);
      wr(8'h1c, 32'h0);
      cyc(2);
      chk(crystal_in_pin, 0);
   endtask

   task automatic t_pll;
      wr(8'h20, 32'h0005_031c);
      cyc(1);
      chk(mul, 0);
      unl(8'h20);
      wr(8'h20, 32'h0005_031c);
      cyc(2);
      chk({ref_sel, div, mul}, {2'd2, 4'd3, 6'd5});
      chk({div2, wbw}, 2'b11);
      wr(8'h20, 32'h0007_031c);
      cyc(1);
      chk(mul, 5);
      unl(8'h20);
      wr(8'h00, 32'h0);
      wr(8'h20, 32'h0007_031c);
      cyc(1);
      chk(mul, 5);
      unl(8'h20);
      wr(8'h20, 32'h0005_031d);
      cyc(2);
      chk(pll_en, 1);
      cyc(5);
      chk(pgate, 0);
      lock <= 1'b1;
      cyc(6);
      chk(pgate, 1);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[2], 1);
      unl(8'h20);
      wr(8'h20, 32'h0009_031d);
      cyc(1);
      chk(mul, 5);
      lock <= 1'b0;
      cyc(6);
      chk(pgate, 0);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[3:2], 2'b10);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd[3:2], 2'b11);
      unl(8'h20);
      wr(8'h20, 32'h0009_031c);
      cyc(2);
      chk({pll_en, mul}, {1'b0, 6'd5});
      unl(8'h20);
      wr(8'h20, 32'h0009_031c);
      cyc(2);
      chk(mul, 9);
   endtask

   task automatic t_dfll;
      wr(8'h10, 32'hf);
      wr(8'h24, 32'h1);
      cyc(1);
      chk(dconf, 0);
      unl(8'h24);
      wr(8'h24, 32'h1);
      cyc(1);
      chk(dconf, 1);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd[1], 0);
      unl(8'h24);
      wr(8'h24, 32'h0);
      cyc(1);
      chk(dconf, 1);
      dans(4'h9);
      chk(rd[1], 1);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd[1], 1);
      wr(8'h28, 32'h1);
      cyc(1);
      chk(req ^ ack, 1);
      dans(4'h6);
      apb(1'b0, 8'h2c, 32'h0);
      chk(rd[3:0], 4'h6);
      unl(8'h24);
      wr(8'h24, 32'h0);
      cyc(1);
      chk(dconf, 0);
      dans(4'h0);
   endtask

   // ------------------------------------------------------------
   // sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      cyc(10);
      rst <= 1'b0;
      cyc(1);
      t_reset;
      t_osc;
      t_pll;
      t_dfll;
      complete_run;
   end

   // whole run needs about 250 cycles
   initial
   begin
      #(40 * 6000);
      bad_count++;
      complete_run;
   end

endmodule // tb_ccs_top

`default_nettype wire
